// ---- src/asp_pkg.sv ----
package asp_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_PORT = 16'hff91;
  localparam logic [15:0] IDX_MODE = 16'hff98;
  localparam logic [15:0] IDX_DIV  = 16'hff99;
  localparam logic [15:0] IDX_CTRL = 16'hff9a;
  localparam logic [15:0] IDX_TXH  = 16'hff9b;
  localparam logic [15:0] IDX_FLAG = 16'hff9c;
  localparam logic [15:0] IDX_RXH  = 16'hff9d;

  // serial_mode_reg fields
  localparam int MODE_SYNC   = 7;
  localparam int MODE_CHR7   = 6;
  localparam int MODE_PAR_EN = 5;
  localparam int MODE_PAR_OD = 4;
  localparam int MODE_STOP2  = 3;
  localparam int MODE_MP     = 2;
  localparam int MODE_CKS_HI = 1;
  localparam int MODE_CKS_LO = 0;

  // serial_control_reg fields
  localparam int CTRL_TX_EN  = 5;
  localparam int CTRL_RX_EN  = 4;

  // serial_flag_reg fields
  localparam int FLAG_TX_EMPTY = 7;
  localparam int FLAG_RX_FULL  = 6;
  localparam int FLAG_OVERRUN  = 5;
  localparam int FLAG_FRAMING  = 4;
  localparam int FLAG_PAR_ERR  = 3;
  localparam int FLAG_TX_END   = 2;

  // port control fields
  localparam int PORT_RX_INV = 0;
  localparam int PORT_TX_SEL = 4;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TXH_RST  = 8'hff;
  localparam logic [7:0] RXH_RST  = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;

  // sixteen sample ticks per bit, bit centre on the eighth
  localparam logic [3:0] TICK_LAST   = 4'hf;
  localparam logic [3:0] TICK_SAMPLE = 4'h7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asp_tx_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_type;

endpackage

// ---- src/asp_serial_port.sv ----
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int ADDR_W = 18
)(
  input  wire logic              mclk,     // system clock, 50 MHz
  input  wire logic              rst_n,    // synchronous reset
  input  wire logic              standby,  // standby or module-standby request
  input  wire logic [ADDR_W-1:0] awaddr,   // write address
  input  wire logic              awvalid,  // write address valid
  output logic                   awready,  // write address ready
  input  wire logic [31:0]       wdata,    // write data
  input  wire logic [3:0]        wstrb,    // write byte strobes
  input  wire logic              wvalid,   // write data valid
  output logic                   wready,   // write data ready
  output logic [1:0]             bresp,    // write response
  output logic                   bvalid,   // write response valid
  input  wire logic              bready,   // write response ready
  input  wire logic [ADDR_W-1:0] araddr,   // read address
  input  wire logic              arvalid,  // read address valid
  output logic                   arready,  // read address ready
  output logic [31:0]            rdata,    // read data
  output logic [1:0]             rresp,    // read response
  output logic                   rvalid,   // read data valid
  input  wire logic              rready,   // read data ready
  input  wire logic              rx_line,  // serial receive pin
  output logic                   tx_line   // serial transmit pin
);

  if (ADDR_W < 18)
  begin : g_bad_addr
    $error("ADDR_W must reach the register indices");
  end

  typedef struct packed {
    logic [7:0]        mode;
    logic [7:0]        div;
    logic [7:0]        ctrl;
    logic [7:0]        port;
    logic [7:0]        txh;
    logic [7:0]        rxh;
    logic              tx_empty_flag;
    logic              rx_full_flag;
    logic              overrun_flag;
    logic              framing_flag;
    logic              parity_err_flag;
    logic              tend;
    logic [7:0]        seen;
    logic [7:0]        presc;
    logic [7:0]        divc;
    logic              tick;
    asp_tx_type        tx_st;
    logic [3:0]        tx_cnt;
    logic [2:0]        tx_bit;
    logic [7:0]        tx_sh;
    logic              tx_par;
    logic              tx_line;
    logic              rx_s1;
    logic              rx_s2;
    logic              rx_s3;
    asp_rx_type        rx_st;
    logic [3:0]        rx_cnt;
    logic [2:0]        rx_bit;
    logic [7:0]        rx_sh;
    logic              rx_par;
    logic              rx_perr;
    logic              aw_rdy;
    logic              w_rdy;
    logic [ADDR_W-1:0] waddr;
    logic [7:0]        wd;
    logic              wstb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } asp_state_type;

  asp_state_type s;
  asp_state_type n;

  logic       rx_fin;
  logic       wr_go;
  logic       rd_hs;
  logic       tx_load;
  logic       line;
  logic [7:0] flags;
  logic [7:0] rd_val;
  logic [7:0] tx_dat;

  function automatic logic [15:0] reg_idx(input logic [ADDR_W-1:0] a);
    return a[17:2];
  endfunction

  // index of the last data bit: 7, 6 or 4
  function automatic logic [2:0] data_last(input logic [7:0] m);
    if (m[MODE_PAR_EN] && m[MODE_MP])
      return 3'd4;
    return m[MODE_CHR7] ? 3'd6 : 3'd7;
  endfunction

  function automatic logic par_on(input logic [7:0] m);
    return m[MODE_PAR_EN] && !m[MODE_MP] && !m[MODE_SYNC];
  endfunction

  // prescaler wrap: 2*4^n clocks per sample tick step
  function automatic logic [7:0] presc_lim(input logic [1:0] cks);
    unique case (cks)
      2'b00: return 8'h01;
      2'b01: return 8'h07;
      2'b10: return 8'h1f;
      2'b11: return 8'h7f;
    endcase
  endfunction

  function automatic asp_state_type rst_state();
    asp_state_type v;
    v        = '0;
    v.mode   = MODE_RST;
    v.div    = DIV_RST;
    v.ctrl   = CTRL_RST;
    v.port   = PORT_RST;
    v.txh    = TXH_RST;
    v.rxh    = RXH_RST;
    v.tx_empty_flag   = 1'b1;
    v.tend   = 1'b1;
    v.tx_st  = TX_IDLE;
    v.rx_st  = RX_IDLE;
    v.tx_line = 1'b1;
    v.rx_s1  = 1'b1;
    v.rx_s2  = 1'b1;
    v.rx_s3  = 1'b1;
    v.aw_rdy = 1'b1;
    v.w_rdy  = 1'b1;
    v.ar_rdy = 1'b1;
    return v;
  endfunction

  always_comb
  begin
    n       = s;
    rx_fin  = 1'b0;
    tx_load = 1'b0;
    n.tick  = 1'b0;
    flags   = {s.tx_empty_flag, s.rx_full_flag, s.overrun_flag, s.framing_flag, s.parity_err_flag, s.tend, 2'b00};
    line    = s.rx_s2 ^ s.port[PORT_RX_INV];
    tx_dat  = s.txh & ~(8'hff << ({1'b0, data_last(s.mode)} + 4'd1));

    // 16x sample tick: (prescaler+1)*(divisor+1) clocks apart
    // clock-source bits are stored only; the internal generator always drives the link
    if (s.presc >= presc_lim(s.mode[MODE_CKS_HI:MODE_CKS_LO]))
    begin
      n.presc = 8'h00;
      if (s.divc >= s.div)
      begin
        n.divc = 8'h00;
        n.tick = 1'b1;
      end
      else
        n.divc = s.divc + 8'h01;
    end
    else
      n.presc = s.presc + 8'h01;

    n.rx_s1 = rx_line;
    n.rx_s2 = s.rx_s1;
    n.rx_s3 = line;

    // write channel: address and data taken in either order
    if (awvalid && s.aw_rdy)
    begin
      n.aw_rdy = 1'b0;
      n.waddr  = awaddr;
    end
    if (wvalid && s.w_rdy)
    begin
      n.w_rdy = 1'b0;
      n.wd    = wdata[7:0];
      n.wstb  = wstrb[0];
    end
    wr_go = !s.aw_rdy && !s.w_rdy && !s.bvalid;
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case (reg_idx(s.waddr))
        IDX_MODE: if (s.wstb) n.mode = s.wd;
        IDX_DIV:  if (s.wstb) n.div = s.wd;
        IDX_CTRL: if (s.wstb) n.ctrl = s.wd;
        IDX_PORT: if (s.wstb) n.port = s.wd;
        IDX_RXH:  ;
        IDX_TXH:
          if (s.wstb)
          begin
            n.txh = s.wd;
            if (s.ctrl[CTRL_TX_EN])
            begin
              n.tx_empty_flag = 1'b0;
              n.tend = 1'b0;
            end
          end
        IDX_FLAG:
          if (s.wstb)
          begin
            // only a 0 over a flag seen as 1 clears it
            if (!s.wd[FLAG_TX_EMPTY] && s.seen[FLAG_TX_EMPTY])
            begin
              n.tx_empty_flag = 1'b0;
              n.tend = 1'b0;
            end
            if (!s.wd[FLAG_RX_FULL] && s.seen[FLAG_RX_FULL])
              n.rx_full_flag = 1'b0;
            if (!s.wd[FLAG_OVERRUN] && s.seen[FLAG_OVERRUN])
              n.overrun_flag = 1'b0;
            if (!s.wd[FLAG_FRAMING] && s.seen[FLAG_FRAMING])
              n.framing_flag = 1'b0;
            if (!s.wd[FLAG_PAR_ERR] && s.seen[FLAG_PAR_ERR])
              n.parity_err_flag = 1'b0;
            n.seen = 8'h00;
          end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready)
    begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy  = 1'b1;
    end

    // read channel
    rd_hs  = arvalid && s.ar_rdy;
    rd_val = 8'h00;
    if (rd_hs)
    begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      unique case (reg_idx(araddr))
        IDX_MODE: rd_val = s.mode;
        IDX_DIV:  rd_val = s.div;
        IDX_CTRL: rd_val = s.ctrl;
        IDX_PORT: rd_val = s.port;
        IDX_TXH:  rd_val = s.txh;
        IDX_FLAG:
        begin
          rd_val = flags;
          n.seen = flags;
        end
        IDX_RXH:
        begin
          rd_val = s.rxh;
          n.rx_full_flag = 1'b0;
        end
        default: n.rresp = RESP_SLVERR;
      endcase
      n.rdata = {24'h00_0000, rd_val};
    end
    if (s.rvalid && rready)
    begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    // transmitter; synchronous mode is not served, so it parks idle
    // an idle load waits for a tick so the start bit lasts a full sixteen ticks
    if (s.tx_st == TX_IDLE)
      tx_load = s.tick && s.ctrl[CTRL_TX_EN] && !s.mode[MODE_SYNC] && !s.tx_empty_flag;
    else if (s.tick)
    begin
      n.tx_cnt = s.tx_cnt + 4'd1;
      if (s.tx_cnt == TICK_LAST)
      begin
        unique case (s.tx_st)
          TX_START: n.tx_st = TX_DATA;
          TX_DATA:
            if (s.tx_bit == data_last(s.mode))
              n.tx_st = par_on(s.mode) ? TX_PAR : TX_STOP1;
            else
            begin
              n.tx_bit = s.tx_bit + 3'd1;
              n.tx_sh  = s.tx_sh >> 1;
            end
          TX_PAR:   n.tx_st = TX_STOP1;
          TX_STOP1,
          TX_STOP2:
            if (s.tx_st == TX_STOP1 && s.mode[MODE_STOP2])
              n.tx_st = TX_STOP2;
            else if (s.tx_empty_flag)
            begin
              n.tx_st = TX_IDLE;
              n.tend  = 1'b1;
            end
            else
              tx_load = 1'b1;
          default:  n.tx_st = TX_IDLE;
        endcase
      end
    end
    if (tx_load)
    begin
      n.tx_sh  = tx_dat;
      n.tx_par = ^tx_dat ^ s.mode[MODE_PAR_OD];
      n.tx_empty_flag   = 1'b1;
      n.tx_st  = TX_START;
      n.tx_cnt = 4'h0;
      n.tx_bit = 3'd0;
    end
    if (!s.ctrl[CTRL_TX_EN] || s.mode[MODE_SYNC])
    begin
      n.tx_empty_flag  = 1'b1;
      n.tend  = 1'b1;
      n.tx_st = TX_IDLE;
    end

    // receiver; a pending error flag keeps it from starting
    if (!s.ctrl[CTRL_RX_EN] || s.mode[MODE_SYNC])
      n.rx_st = RX_IDLE;
    else if (s.rx_st == RX_IDLE)
    begin
      if (s.rx_s3 && !line && !s.overrun_flag && !s.framing_flag && !s.parity_err_flag)
      begin
        n.rx_st   = RX_START;
        n.rx_cnt  = 4'h0;
        n.rx_bit  = 3'd0;
        n.rx_par  = 1'b0;
        n.rx_perr = 1'b0;
      end
    end
    else if (s.tick)
    begin
      n.rx_cnt = s.rx_cnt + 4'd1;
      if (s.rx_cnt == TICK_SAMPLE)
      begin
        unique case (s.rx_st)
          RX_START: if (line) n.rx_st = RX_IDLE;
          RX_DATA:
          begin
            n.rx_sh  = {line, s.rx_sh[7:1]};
            n.rx_par = s.rx_par ^ line;
          end
          RX_PAR:   n.rx_perr = (s.rx_par ^ line) != s.mode[MODE_PAR_OD];
          RX_STOP:
          begin
            rx_fin  = 1'b1;
            n.rx_st = RX_IDLE;
          end
          default:  n.rx_st = RX_IDLE;
        endcase
      end
      else if (s.rx_cnt == TICK_LAST)
      begin
        unique case (s.rx_st)
          RX_START: n.rx_st = RX_DATA;
          RX_DATA:
            if (s.rx_bit == data_last(s.mode))
              n.rx_st = par_on(s.mode) ? RX_PAR : RX_STOP;
            else
              n.rx_bit = s.rx_bit + 3'd1;
          RX_PAR:   n.rx_st = RX_STOP;
          RX_STOP:  n.rx_st = RX_IDLE;
          default:  n.rx_st = RX_IDLE;
        endcase
      end
    end
    // hardware sets land after bus clears, so an event is never lost
    if (rx_fin)
    begin
      if (s.rx_full_flag)
        n.overrun_flag = 1'b1;
      else
      begin
        n.rxh = s.rx_sh >> (3'd7 - data_last(s.mode));
        if (!line)
          n.framing_flag = 1'b1;
        if (s.rx_perr)
          n.parity_err_flag = 1'b1;
        if (line && !s.rx_perr)
          n.rx_full_flag = 1'b1;
      end
    end

    if (standby)
    begin
      n.txh   = TXH_RST;
      n.rxh   = RXH_RST;
      n.tx_st = TX_IDLE;
      n.rx_st = RX_IDLE;
    end

    // pin idles high when the transmit function is not selected
    unique case (n.tx_st)
      TX_START: n.tx_line = 1'b0;
      TX_DATA:  n.tx_line = n.tx_sh[0];
      TX_PAR:   n.tx_line = n.tx_par;
      default:  n.tx_line = 1'b1;
    endcase
    if (!s.port[PORT_TX_SEL])
      n.tx_line = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      s <= rst_state();
    else
      s <= n;
  end

  assign awready = s.aw_rdy;
  assign wready  = s.w_rdy;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.ar_rdy;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign tx_line = s.tx_line;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_tx_empty_flag_hold;
    !s.ctrl[CTRL_TX_EN] && !standby |=> s.tx_empty_flag && s.tx_st == TX_IDLE;
  endproperty
  a_tx_empty_flag_hold: assert property (p_tx_empty_flag_hold) else $error("tx empty not held");

  property p_div_reset;
    $rose(rst_n) |-> s.div == DIV_RST && s.rxh == RXH_RST;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("bad reset value");

  sequence s_fast_tick;
    s.tick && s.mode[1:0] == 2'b00 && s.div == 8'h00 ##1 s.mode[1:0] == 2'b00 && s.div == 8'h00;
  endsequence
  property p_tick_gap;
    s_fast_tick |-> !s.tick ##1 s.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sample tick period wrong");

  property p_start_low;
    s.tx_st == TX_START && s.port[PORT_TX_SEL] |-> !tx_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_stop_high;
    s.tx_st == TX_STOP1 || s.tx_st == TX_STOP2 |-> tx_line;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  sequence s_overrun;
    rx_fin && s.rx_full_flag && !standby;
  endsequence
  property p_overrun;
    s_overrun |=> s.overrun_flag && $stable(s.rxh);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun mishandled");

  property p_err_block;
    (s.overrun_flag || s.framing_flag || s.parity_err_flag) && s.rx_st == RX_IDLE |=> s.rx_st == RX_IDLE;
  endproperty
  a_err_block: assert property (p_err_block) else $error("reception resumed");

  property p_rxh_ro;
    wr_go && reg_idx(s.waddr) == IDX_RXH && !rx_fin && !standby |=> $stable(s.rxh);
  endproperty
  a_rxh_ro: assert property (p_rxh_ro) else $error("rx holding written");

  property p_rx_full_flag_clear;
    rd_hs && reg_idx(araddr) == IDX_RXH && !rx_fin |=> !s.rx_full_flag;
  endproperty
  a_rx_full_flag_clear: assert property (p_rx_full_flag_clear) else $error("rx full not cleared");

  property p_frame_err;
    rx_fin && !s.rx_full_flag && !line |=> s.framing_flag && !s.rx_full_flag;
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("framing mishandled");

endmodule

// ---- tb/asp_remote.sv ----
`timescale 1ns/10ps
module asp_remote (
  input  wire logic        tx_line, // design transmit pin
  input  wire logic [15:0] bit_ns,  // bit time in ns
  output logic             rx_line  // design receive pin
);
  logic       lvl = 1'b1;
  logic       inv = 1'b0;
  logic [8:0] got = '0;
  int         nfr = 0;
  time        t_prev = 0;
  time        t_last = 0;

  // an inverted link idles low, so inv flips the idle level too
  assign rx_line = lvl ^ inv;

  // low start, bits lsb first, then whatever stop the caller packed
  task automatic send(logic [11:0] b, int n);
    #3 lvl = 1'b0;
    #(bit_ns);
    for (int i = 0; i < n; i++)
    begin
      lvl = b[i];
      #(bit_ns);
    end
    lvl = 1'b1;
  endtask

  // nine samples at bit centres after each start edge
  always
  begin
    @(negedge tx_line);
    t_prev = t_last;
    t_last = $time;
    #(bit_ns / 2);
    for (int i = 0; i < 9; i++)
    begin
      #(bit_ns);
      got[i] = tx_line;
    end
    nfr++;
  end
endmodule

// ---- tb/asp_serial_port_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module asp_serial_port_tb_top;
  import asp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby = 1'b0;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awready, wready, bvalid, arready, rvalid, tx_line, rx_line;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata;
  logic [15:0] bit_ns = 16'h0280;
  logic [7:0]  d, v, w;
  logic [7:0]  modes [7] = '{8'h00, 8'h40, 8'h34, 8'h20, 8'h30, 8'h10, 8'h04};
  int          n_fail = 0;
  int          checks_done = 0;
  int          nf = 0;
  int          seed = 32'h54d0_5f17;

  always #10 mclk = ~mclk;

  asp_serial_port #(.ADDR_W(18)) asp_serial_port_i (
    .mclk(mclk), .rst_n(rst_n), .standby(standby),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx_line(rx_line), .tx_line(tx_line));

  asp_remote asp_remote_i (.tx_line(tx_line), .bit_ns(bit_ns), .rx_line(rx_line));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo(int k, int lim);
    if (k >= lim)
    begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic wr(logic [15:0] idx, logic [7:0] x);
    int k;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, x};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    tmo(k, 50);
  endtask

  task automatic rd(logic [15:0] idx);
    int k;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata[7:0];
    rs = rresp;
    tmo(k, 50);
  endtask

  task automatic rdchk(logic [15:0] idx, logic [7:0] e);
    rd(idx);
    `CHK(d, e);
  endtask

  task automatic flg(logic [3:0] e);
    rd(IDX_FLAG);
    `CHK(d[6:3], e);
  endtask

  task automatic wflag(int b);
    int k;
    for (k = 0; k < 400; k++)
    begin
      rd(IDX_FLAG);
      if (d[b] === 1'b1) break;
    end
    tmo(k, 400);
  endtask

  task automatic wfr();
    int k;
    nf++;
    for (k = 0; k < 3000 && asp_remote_i.nfr < nf; k++)
      @(posedge mclk);
    tmo(k, 3000);
  endtask

  // expected nine samples after a start edge for a given mode
  function automatic logic [8:0] fr(logic [7:0] m, logic [7:0] x);
    int n;
    logic [8:0] r;
    n = (m[MODE_PAR_EN] && m[MODE_MP]) ? 5 : (m[MODE_CHR7] ? 7 : 8);
    r = 9'h1ff;
    for (int i = 0; i < n; i++)
      r[i] = x[i];
    if (m[MODE_PAR_EN] && !m[MODE_MP])
      r[n] = ^(x & 8'((1 << n) - 1)) ^ m[MODE_PAR_OD];
    return r;
  endfunction

  // odd-parity frame body; bad flips parity, st is the stop level
  function automatic logic [11:0] rf(logic [7:0] x, logic bad, logic st);
    return {2'b11, st, ~(^x) ^ bad, x};
  endfunction

  initial
  begin
    #2_000_000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(IDX_DIV, 8'hff);
    rdchk(IDX_RXH, 8'h00);
    rdchk(IDX_FLAG, 8'h84);
    rd(16'hff90);
    `CHK(rs, RESP_SLVERR);
    wr(16'hff90, 8'h00);
    `CHK(rs, RESP_SLVERR);
    wr(IDX_RXH, 8'h5a);
    rdchk(IDX_RXH, 8'h00);
    v = 8'($random(seed));
    wr(IDX_DIV, v);
    rdchk(IDX_DIV, v);
    `CHK(rs, RESP_OKAY);
    $display("test registers done");
    wr(IDX_PORT, 8'h10);
    wr(IDX_DIV, 8'h00);
    wr(IDX_CTRL, 8'h10);
    wr(IDX_TXH, 8'h3c);
    rdchk(IDX_FLAG, 8'h84);
    wr(IDX_CTRL, 8'h30);
    foreach (modes[j])
    begin
      wflag(FLAG_TX_END);
      wr(IDX_MODE, modes[j]);
      v = 8'($random(seed));
      wr(IDX_TXH, v);
      wfr();
      `CHK(asp_remote_i.got, fr(modes[j], v));
    end
    // clock-synchronous mode is not served: a holding write sends nothing
    wflag(FLAG_TX_END);
    wr(IDX_MODE, 8'h80);
    wr(IDX_TXH, 8'h11);
    repeat (400) @(posedge mclk);
    `CHK(asp_remote_i.nfr, nf);
    $display("test tx formats done");
    // two back-to-back characters, start spacing equals one full frame
    wr(IDX_DIV, 8'h01);
    bit_ns <= 16'h0500;
    for (int j = 0; j < 2; j++)
    begin
      wflag(FLAG_TX_END);
      wr(IDX_MODE, j ? 8'h08 : 8'h00);
      wr(IDX_TXH, 8'h55);
      wflag(FLAG_TX_EMPTY);
      wr(IDX_TXH, 8'haa);
      wfr();
      wfr();
      `CHK(asp_remote_i.t_last - asp_remote_i.t_prev, (10 + j) * 1280);
    end
    $display("test tx timing done");
    wflag(FLAG_TX_END);
    wr(IDX_DIV, 8'h00);
    wr(IDX_MODE, 8'h30);
    bit_ns <= 16'h0280;
    v = 8'($random(seed));
    w = 8'($random(seed));
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    flg(4'b1000);
    rdchk(IDX_RXH, v);
    flg(4'b0000);
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    asp_remote_i.send(rf(w, 1'b0, 1'b1), 10);
    flg(4'b1100);
    wr(IDX_FLAG, 8'hff);
    flg(4'b1100);
    rdchk(IDX_RXH, v);
    wr(IDX_FLAG, 8'h84);
    flg(4'b0000);
    $display("test rx overrun done");
    asp_remote_i.send(rf(w, 1'b1, 1'b1), 10);
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    wr(IDX_CTRL, 8'h20);
    flg(4'b0001);
    rdchk(IDX_RXH, w);
    wr(IDX_FLAG, 8'h84);
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    flg(4'b0000);
    wr(IDX_CTRL, 8'h30);
    asp_remote_i.send(rf(v, 1'b0, 1'b0), 10);
    flg(4'b0010);
    rdchk(IDX_RXH, v);
    wr(IDX_FLAG, 8'h84);
    $display("test rx errors done");
    // second stop slot low is taken as the next start bit
    wr(IDX_MODE, 8'h38);
    asp_remote_i.send(rf(w, 1'b0, 1'b1), 10);
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    flg(4'b1100);
    rdchk(IDX_RXH, w);
    wr(IDX_FLAG, 8'h84);
    wr(IDX_CTRL, 8'h20);
    wr(IDX_PORT, 8'h11);
    asp_remote_i.inv = 1'b1;
    wr(IDX_CTRL, 8'h30);
    asp_remote_i.send(rf(v, 1'b0, 1'b1), 10);
    flg(4'b1000);
    rdchk(IDX_RXH, v);
    standby <= 1'b1;
    repeat (3) @(posedge mclk);
    standby <= 1'b0;
    rdchk(IDX_RXH, 8'h00);
    $display("test rx options done");
    end_sim();
  end
endmodule
